// ---- design/mcs_status_regs.svh ----
// Offsets, field positions, command codes and reset values of the motion status block
`ifndef MCS_STATUS_REGS_SVH
`define MCS_STATUS_REGS_SVH
`define MCS_ADDR_W 3
`define MCS_ADDR_CMD 3'h0
`define MCS_ADDR_MAIN 3'h0
`define MCS_ADDR_AXIS 3'h1
`define MCS_CMD_FIX_PLUS 8'h20
`define MCS_CMD_FIX_MINUS 8'h21
`define MCS_CMD_CONT_PLUS 8'h22
`define MCS_CMD_CONT_MINUS 8'h23
`define MCS_CMD_FIN_CLEAR 8'h25
`define MCS_CMD_DECEL_STOP 8'h26
`define MCS_CMD_SUDDEN_STOP 8'h27
`define MCS_CMD_AXIS_SELECT 8'h1F
`define MCS_CMD_AXMASK_LSB 8
`define MCS_MAIN_BUSY_LSB 0
`define MCS_MAIN_ERR_LSB 4
`define MCS_MAIN_IBUSY 8
`define MCS_MAIN_NEXT 9
`define MCS_MAIN_QUAD_LSB 10
`define MCS_MAIN_STACK_LSB 13
`define MCS_AX_FIN_LSB 12
`define MCS_AX_HALT_LSB 8
`define MCS_RESET_WORD 16'h0000
`define MCS_RESET_AXIS 1'b0
`endif

// ---- design/mcs_status_pkg.sv ----
// Shared types of the motion status block
package mcs_status_pkg;
	typedef logic [15:0] mcs_word_t;
	typedef logic [31:0] mcs_pos_t;
	typedef logic [7:0] mcs_cmd_t;
	typedef logic [2:0] mcs_quad_t;
	typedef logic [1:0] mcs_stack_t;
	typedef logic [2:0] mcs_halt_t;
endpackage : mcs_status_pkg

// ---- design/mcs_axis_if.sv ----
// Per-axis signals between the top and one axis status module
`timescale 1ns/1ns
interface mcs_axis_if;
	logic pulse_busy;
	logic inpos_en;
	logic in_pos;
	logic drive_cmd;
	logic clr_cmd;
	logic stop_cmd;
	logic sw_lim_p;
	logic sw_lim_m;
	logic lmt_p;
	logic lmt_m;
	logic alarm;
	logic alarm_en;
	logic emergency_finish_flag;
	mcs_status_pkg::mcs_halt_t halt_in;
	mcs_status_pkg::mcs_halt_t halt_en;
	logic mult_err;
	mcs_status_pkg::mcs_pos_t pos;
	mcs_status_pkg::mcs_pos_t cmp_up;
	mcs_status_pkg::mcs_pos_t cmp_lo;
	logic accel;
	logic cruise;
	logic decel;
	logic jerk_up;
	logic busy;
	logic err;
	logic halt;
	mcs_status_pkg::mcs_word_t status;
	modport top (output pulse_busy, inpos_en, in_pos, drive_cmd, clr_cmd, stop_cmd, sw_lim_p, sw_lim_m,
		lmt_p, lmt_m, alarm, alarm_en, emergency_finish_flag, halt_in, halt_en, mult_err, pos, cmp_up, cmp_lo, accel, cruise,
		decel, jerk_up, input busy, err, halt, status);
	modport axis (input pulse_busy, inpos_en, in_pos, drive_cmd, clr_cmd, stop_cmd, sw_lim_p, sw_lim_m,
		lmt_p, lmt_m, alarm, alarm_en, emergency_finish_flag, halt_in, halt_en, mult_err, pos, cmp_up, cmp_lo, accel, cruise,
		decel, jerk_up, output busy, err, halt, status);
endinterface : mcs_axis_if

// ---- design/mcs_axis_stat.sv ----
// Busy, error, finish-cause and per-axis status word of one axis
`timescale 1ns/1ns
`include "mcs_status_regs.svh"
module mcs_axis_stat (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Axis signals
	mcs_axis_if.axis ax
);
	logic busy_q;
	logic busy_d;
	logic [5:0] err_q;
	logic [5:0] err_set;
	logic [3:0] fin_q;
	logic [3:0] fin_set;
	logic [2:0] hfin_q;
	logic [2:0] hfin_set;
	logic halt_q;
	logic any_cause;
	logic clr;
	logic cmp_ge_up;
	logic cmp_lt_lo;
	logic [2:0] ramp;
	mcs_status_pkg::mcs_word_t status_q;
	mcs_status_pkg::mcs_word_t status_d;

	// Busy holds past the last pulse until in-position arrives, when that input is in use
	assign busy_d = ax.pulse_busy | (busy_q & ax.inpos_en & ~ax.in_pos);
	assign clr = ax.drive_cmd | ax.clr_cmd;
	// Software limit only counts while driving; emergency always counts
	assign err_set = {ax.emergency_finish_flag, ax.alarm & ax.alarm_en, ax.lmt_m, ax.lmt_p,
		ax.sw_lim_m & busy_q, ax.sw_lim_p & busy_q};
	assign fin_set = {ax.emergency_finish_flag, ax.alarm & ax.alarm_en, ax.lmt_m, ax.lmt_p} & {4{busy_q}};
	assign hfin_set = ax.halt_in & ax.halt_en & {3{busy_q}};
	assign any_cause = |err_set | |hfin_set | ax.stop_cmd;
	assign cmp_ge_up = $signed(ax.pos) >= $signed(ax.cmp_up);
	assign cmp_lt_lo = $signed(ax.pos) < $signed(ax.cmp_lo);
	// Only one ramp phase shows at a time; if the generator reports two, deceleration wins over cruise and cruise over acceleration
	assign ramp = !busy_q ? 3'h0 : ax.decel ? 3'h4 : ax.cruise ? 3'h2 : ax.accel ? 3'h1 : 3'h0;
	assign status_d = {fin_q, 1'b0, hfin_q, 2'b00, ax.jerk_up & busy_q, ramp, cmp_lt_lo, cmp_ge_up};

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			busy_q <= `MCS_RESET_AXIS;
			err_q <= 6'h00;
			fin_q <= 4'h0;
			hfin_q <= 3'h0;
			halt_q <= 1'b0;
			status_q <= `MCS_RESET_WORD;
		end
		else
		begin
			busy_q <= busy_d;
			// Set wins over clear so a cause arriving with the clear is kept
			err_q <= (clr ? 6'h00 : err_q) | err_set;
			fin_q <= (clr ? 4'h0 : fin_q) | fin_set;
			hfin_q <= (clr ? 3'h0 : hfin_q) | hfin_set;
			halt_q <= busy_q & any_cause;
			status_q <= status_d;
		end
	end

	assign ax.busy = busy_q;
	assign ax.err = |err_q | ax.mult_err | |fin_q;
	assign ax.halt = halt_q;
	assign ax.status = status_q;

	a_busy_inpos_hold: assert property (@(posedge clk) disable iff (rst)
		busy_q && !ax.pulse_busy && ax.inpos_en && !ax.in_pos |=> busy_q)
		else $error("busy dropped before in-position");
	a_fin_keep: assert property (@(posedge clk) disable iff (rst)
		!clr && fin_q[3] |=> fin_q[3])
		else $error("emergency finish cause lost");
	a_fin_clear: assert property (@(posedge clk) disable iff (rst)
		clr && fin_set == 4'h0 |=> fin_q == 4'h0)
		else $error("finish cause not cleared");
	a_halt_emg: assert property (@(posedge clk) disable iff (rst)
		busy_q && ax.emergency_finish_flag |=> halt_q)
		else $error("drive not halted on emergency");
	a_ramp_onehot: assert property (@(posedge clk) disable iff (rst)
		$countones(status_q[4:2]) <= 1)
		else $error("two ramp phases at once");
	a_cmp_upper: assert property (@(posedge clk) disable iff (rst)
		$signed(ax.pos) >= $signed(ax.cmp_up) |=> status_q[0])
		else $error("upper compare flag wrong");
	c_inpos_wait: cover property (@(posedge clk) disable iff (rst)
		busy_q && !ax.pulse_busy && ax.inpos_en ##1 ax.in_pos ##1 !busy_q);
	c_limit_finish: cover property (@(posedge clk) disable iff (rst) busy_q && ax.lmt_p ##1 halt_q);
endmodule : mcs_axis_stat

// ---- design/mcs_status_top.sv ----
// Main and per-axis status words of a two-axis motion controller
`timescale 1ns/1ns
`include "mcs_status_regs.svh"
module mcs_status_top (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic SRST,
	// Host parallel bus
	input wire logic CS_N,
	input wire logic RD_N,
	input wire logic WR_N,
	input wire logic [`MCS_ADDR_W-1:0] ADDR,
	input wire logic [15:0] DATA_IN,
	output logic [15:0] DATA_OUT,
	output logic DATA_OE_N,
	// Per-axis drive state, index 0 is X
	input wire logic [1:0] PULSE_BUSY,
	input wire logic [1:0] INPOS_EN,
	input wire logic [1:0] IN_POSITION,
	input wire logic [1:0] SOFT_LIMIT_PLUS,
	input wire logic [1:0] SOFT_LIMIT_MINUS,
	input wire logic [1:0] PLUS_LIMIT,
	input wire logic [1:0] MINUS_LIMIT,
	input wire logic [1:0] SERVO_ALARM,
	input wire logic [1:0] ALARM_EN,
	input wire logic [5:0] EXT_HALT,
	input wire logic [5:0] EXT_HALT_EN,
	input wire logic [1:0] MULTI_ERR,
	input wire logic [1:0] ACCELERATING,
	input wire logic [1:0] CRUISING,
	input wire logic [1:0] DECELERATING,
	input wire logic [1:0] JERK_RISING,
	input wire logic [63:0] POSITION,
	input wire logic [63:0] UPPER_COMPARE,
	input wire logic [63:0] LOWER_COMPARE,
	// Shared inputs
	input wire logic EMERGENCY_STOP_N,
	input wire logic INTERP_BUSY,
	input wire logic NEXT_NODE_READY,
	input wire logic CIRCLE_ACTIVE,
	input wire logic [2:0] CIRCLE_QUADRANT,
	input wire logic PATTERN_ACTIVE,
	input wire logic [1:0] PATTERN_STACK_LEVEL,
	// Drive control outputs
	output logic [1:0] DRIVE_HALT,
	output logic [1:0] AXIS_BUSY
);
	mcs_axis_if ax_if[2] ();

	logic wr_q;
	logic axis_sel_q;
	logic oe_n_q;
	logic [15:0] dout_q;
	logic [1:0] halt_q;
	logic [1:0] abusy_q;
	mcs_status_pkg::mcs_word_t main_q;
	mcs_status_pkg::mcs_word_t main_d;
	mcs_status_pkg::mcs_word_t axis_word;
	mcs_status_pkg::mcs_cmd_t cmd_code;
	logic wr_take;
	logic rd_act;
	logic [1:0] cmd_mask;
	logic is_drive;
	logic is_clear;
	logic is_stop;
	logic is_select;
	logic [1:0] busy_v;
	logic [1:0] err_v;
	logic [15:0] rd_data;

	// A write is taken once, on the first cycle of the strobe
	assign wr_take = !CS_N && !WR_N && !wr_q && ADDR == `MCS_ADDR_CMD;
	assign rd_act = !CS_N && !RD_N;
	assign cmd_code = DATA_IN[7:0];
	assign cmd_mask = DATA_IN[`MCS_CMD_AXMASK_LSB+1:`MCS_CMD_AXMASK_LSB];
	assign is_drive = wr_take && (cmd_code == `MCS_CMD_FIX_PLUS || cmd_code == `MCS_CMD_FIX_MINUS
		|| cmd_code == `MCS_CMD_CONT_PLUS || cmd_code == `MCS_CMD_CONT_MINUS);
	assign is_clear = wr_take && cmd_code == `MCS_CMD_FIN_CLEAR;
	assign is_stop = wr_take && (cmd_code == `MCS_CMD_DECEL_STOP || cmd_code == `MCS_CMD_SUDDEN_STOP);
	assign is_select = wr_take && cmd_code == `MCS_CMD_AXIS_SELECT;

	for (genvar i = 0; i < 2; i++)
	begin : g_axis
		assign ax_if[i].pulse_busy = PULSE_BUSY[i];
		assign ax_if[i].inpos_en = INPOS_EN[i];
		assign ax_if[i].in_pos = IN_POSITION[i];
		assign ax_if[i].drive_cmd = is_drive && cmd_mask[i];
		assign ax_if[i].clr_cmd = is_clear && cmd_mask[i];
		assign ax_if[i].stop_cmd = is_stop && cmd_mask[i];
		assign ax_if[i].sw_lim_p = SOFT_LIMIT_PLUS[i];
		assign ax_if[i].sw_lim_m = SOFT_LIMIT_MINUS[i];
		assign ax_if[i].lmt_p = PLUS_LIMIT[i];
		assign ax_if[i].lmt_m = MINUS_LIMIT[i];
		assign ax_if[i].alarm = SERVO_ALARM[i];
		assign ax_if[i].alarm_en = ALARM_EN[i];
		assign ax_if[i].emergency_finish_flag = !EMERGENCY_STOP_N;
		assign ax_if[i].halt_in = EXT_HALT[3*i+2:3*i];
		assign ax_if[i].halt_en = EXT_HALT_EN[3*i+2:3*i];
		assign ax_if[i].mult_err = MULTI_ERR[i];
		assign ax_if[i].pos = POSITION[32*i+31:32*i];
		assign ax_if[i].cmp_up = UPPER_COMPARE[32*i+31:32*i];
		assign ax_if[i].cmp_lo = LOWER_COMPARE[32*i+31:32*i];
		assign ax_if[i].accel = ACCELERATING[i];
		assign ax_if[i].cruise = CRUISING[i];
		assign ax_if[i].decel = DECELERATING[i];
		assign ax_if[i].jerk_up = JERK_RISING[i];
		assign busy_v[i] = ax_if[i].busy;
		assign err_v[i] = ax_if[i].err;
		mcs_axis_stat u_axis (
			.clk(REF_CLK),
			.rst(SRST),
			.ax(ax_if[i])
		);
	end

	// Per-axis word follows the axis chosen last; X until the first select
	assign axis_word = axis_sel_q ? ax_if[1].status : ax_if[0].status;
	// Quadrant and stack level only mean something in their own interpolation mode
	assign main_d = {1'b0,
		PATTERN_ACTIVE ? PATTERN_STACK_LEVEL : 2'b00,
		CIRCLE_ACTIVE ? CIRCLE_QUADRANT : 3'h0,
		NEXT_NODE_READY,
		INTERP_BUSY,
		2'b00, err_v,
		2'b00, busy_v};
	assign rd_data = ADDR == `MCS_ADDR_MAIN ? main_q : ADDR == `MCS_ADDR_AXIS ? axis_word : 16'h0000;

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			wr_q <= 1'b0;
			axis_sel_q <= `MCS_RESET_AXIS;
			oe_n_q <= 1'b1;
			dout_q <= `MCS_RESET_WORD;
			main_q <= `MCS_RESET_WORD;
			halt_q <= 2'b00;
			abusy_q <= 2'b00;
		end
		else
		begin
			wr_q <= !CS_N && !WR_N;
			// Y is chosen only when the mask names Y alone; both or X alone chooses X
			if (is_select && cmd_mask != 2'b00)
				axis_sel_q <= cmd_mask == 2'b10;
			oe_n_q <= !rd_act;
			dout_q <= rd_act ? rd_data : 16'h0000;
			main_q <= main_d;
			halt_q <= {ax_if[1].halt, ax_if[0].halt};
			abusy_q <= busy_v;
		end
	end

	assign DATA_OUT = dout_q;
	assign DATA_OE_N = oe_n_q;
	assign DRIVE_HALT = halt_q;
	assign AXIS_BUSY = abusy_q;

	a_main_unused: assert property (@(posedge REF_CLK) disable iff (SRST)
		main_q[15] == 1'b0 && main_q[7:6] == 2'b00 && main_q[3:2] == 2'b00)
		else $error("unused main status bit set");
	a_main_busy: assert property (@(posedge REF_CLK) disable iff (SRST)
		##1 main_q[1:0] == $past(busy_v))
		else $error("busy bits do not follow axes");
	a_main_error: assert property (@(posedge REF_CLK) disable iff (SRST)
		ax_if[0].err |=> main_q[4])
		else $error("X error bit not shown");
	a_interp_busy: assert property (@(posedge REF_CLK) disable iff (SRST)
		INTERP_BUSY |=> main_q[8])
		else $error("interpolation busy not shown");
	a_next_ready: assert property (@(posedge REF_CLK) disable iff (SRST)
		!NEXT_NODE_READY |=> !main_q[9])
		else $error("next node ready shown falsely");
	a_quadrant: assert property (@(posedge REF_CLK) disable iff (SRST)
		CIRCLE_ACTIVE |=> main_q[12:10] == $past(CIRCLE_QUADRANT))
		else $error("quadrant wrong");
	a_stack_level: assert property (@(posedge REF_CLK) disable iff (SRST)
		PATTERN_ACTIVE |=> main_q[14:13] == $past(PATTERN_STACK_LEVEL))
		else $error("stack level wrong");
	a_axis_read: assert property (@(posedge REF_CLK) disable iff (SRST)
		rd_act && ADDR == `MCS_ADDR_AXIS && axis_sel_q |=> !DATA_OE_N && DATA_OUT == $past(ax_if[1].status))
		else $error("axis word not from selected axis");
	a_halt_stop: assert property (@(posedge REF_CLK) disable iff (SRST)
		is_stop && cmd_mask[0] && busy_v[0] |=> ##1 DRIVE_HALT[0])
		else $error("stop command did not halt X");
	c_read_main: cover property (@(posedge REF_CLK) disable iff (SRST) rd_act && ADDR == `MCS_ADDR_MAIN);
	c_select_y: cover property (@(posedge REF_CLK) disable iff (SRST) is_select && cmd_mask == 2'b10);
	c_clear_cmd: cover property (@(posedge REF_CLK) disable iff (SRST) is_clear && err_v[0]);
endmodule : mcs_status_top

// ---- verification/mcs_host_model.sv ----
// Host CPU model that reads and writes the status block over the parallel bus
`timescale 1ns/1ns
module mcs_host_model (
	// Clock
	input wire logic clk,
	// Bus towards the block
	output logic cs_n,
	output logic rd_n,
	output logic wr_n,
	output logic [2:0] addr,
	output mcs_status_pkg::mcs_word_t data_in,
	// Answer from the block
	input wire mcs_status_pkg::mcs_word_t data_out,
	input wire logic data_oe_n
);
	initial
	begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		addr = 3'h7;
		data_in = 16'hFFFF;
	end

	// Strobe held until the enable is seen low; a hung bus returns unknown data
	task automatic rd(input logic [2:0] a, output mcs_status_pkg::mcs_word_t d);
		int n;
		n = 0;
		@(posedge clk);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		addr <= a;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (data_oe_n !== 1'b0 && n < 8);
		d = (data_oe_n === 1'b0) ? data_out : 16'hXXXX;
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		addr <= ~a;
	endtask : rd

	// Released lines show the inverse so stale values never look valid
	task automatic wr(input logic [2:0] a, input mcs_status_pkg::mcs_word_t d);
		@(posedge clk);
		cs_n <= 1'b0;
		wr_n <= 1'b0;
		addr <= a;
		data_in <= d;
		@(posedge clk);
		cs_n <= 1'b1;
		wr_n <= 1'b1;
		addr <= ~a;
		data_in <= ~d;
		@(posedge clk);
	endtask : wr
endmodule : mcs_host_model

// ---- verification/test_motion_status_registers.sv ----
// Self-checking bench of the motion status block
`timescale 1ns/1ns
module test_motion_status_registers;
	logic clk, srst, cs_n, rd_n, wr_n, oe_n, emg_n, ib, nn, ca, pa;
	logic [2:0] addr, cq;
	logic [15:0] din, dout;
	logic [1:0] pb, ie, ip, slp, slm, lp, lm, al, ae, me, ac, cr, de, jr, ps, halt, busy;
	logic [5:0] eh, ehe;
	logic [63:0] pos, up, lo;
	logic [31:0] lf = 32'h0000FEE3;
	int checks = 0;
	int bad_count = 0;
	mcs_status_pkg::mcs_word_t w;

	mcs_host_model host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(din),
		.data_out(dout), .data_oe_n(oe_n));

	mcs_status_top dut (.REF_CLK(clk), .SRST(srst), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n), .ADDR(addr),
		.DATA_IN(din), .DATA_OUT(dout), .DATA_OE_N(oe_n), .PULSE_BUSY(pb), .INPOS_EN(ie), .IN_POSITION(ip),
		.SOFT_LIMIT_PLUS(slp), .SOFT_LIMIT_MINUS(slm), .PLUS_LIMIT(lp), .MINUS_LIMIT(lm), .SERVO_ALARM(al),
		.ALARM_EN(ae), .EXT_HALT(eh), .EXT_HALT_EN(ehe), .MULTI_ERR(me), .ACCELERATING(ac), .CRUISING(cr),
		.DECELERATING(de), .JERK_RISING(jr), .POSITION(pos), .UPPER_COMPARE(up), .LOWER_COMPARE(lo),
		.EMERGENCY_STOP_N(emg_n), .INTERP_BUSY(ib), .NEXT_NODE_READY(nn), .CIRCLE_ACTIVE(ca),
		.CIRCLE_QUADRANT(cq), .PATTERN_ACTIVE(pa), .PATTERN_STACK_LEVEL(ps), .DRIVE_HALT(halt), .AXIS_BUSY(busy));

	function automatic logic [31:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf;
	endfunction : rnd

	function automatic mcs_status_pkg::mcs_word_t exp_main();
		exp_main = 16'h0000;
		exp_main[1:0] = pb;
		exp_main[5:4] = me;
		exp_main[8] = ib;
		exp_main[9] = nn;
		if (ca)
			exp_main[12:10] = cq;
		if (pa)
			exp_main[14:13] = ps;
	endfunction : exp_main

	// Only valid while the axis is busy with a single phase and no end cause
	function automatic mcs_status_pkg::mcs_word_t exp_axis(input int a);
		mcs_status_pkg::mcs_pos_t p, u, l;
		p = pos[32 * a +: 32];
		u = up[32 * a +: 32];
		l = lo[32 * a +: 32];
		exp_axis = 16'h0000;
		exp_axis[0] = $signed(p) >= $signed(u);
		exp_axis[1] = $signed(p) < $signed(l);
		exp_axis[4:2] = {de[a], cr[a], ac[a]};
		exp_axis[5] = jr[a];
	endfunction : exp_axis

	task automatic cmp_word(input mcs_status_pkg::mcs_word_t got, input mcs_status_pkg::mcs_word_t exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %0t word %h expected %h", $time, got, exp);
		end
	endtask : cmp_word

	task automatic cmp_bits(input logic [1:0] got, input logic [1:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %0t bits %b expected %b", $time, got, exp);
		end
	endtask : cmp_bits

	task automatic summarize();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial
	begin
		#1000000;
		bad_count++;
		summarize();
	end

	initial
	begin
		logic [31:0] r;
		logic [63:0] p;
		logic [2:0] ph;
		{pb, ie, ip, slp, slm, lp, lm, al, ae, me, ac, cr, de, jr, ps, eh, ehe} = '0;
		{pos, up, lo, ib, nn, ca, cq, pa} = '0;
		emg_n = 1'b1;
		srst = 1'b1;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		host.rd(3'h0, w);
		cmp_word(w, 16'h0000);
		host.rd(3'h1, w);
		// Position and upper bound both sit at zero, so the at-least flag is up
		cmp_word(w, 16'h0001);
		repeat (40)
		begin
			r = rnd();
			@(posedge clk);
			pb <= r[1:0];
			me <= r[3:2];
			ib <= r[4];
			nn <= r[5];
			ca <= r[6];
			cq <= r[9:7];
			pa <= r[10];
			ps <= r[12:11];
			host.wr(3'(r[15:13] % 3'h7 + 3'h1), r[31:16]);
			host.rd(3'h0, w);
			cmp_word(w, exp_main());
		end
		// Equal bounds first, so the at-least edge of the compare is hit
		for (int k = 0; k < 16; k++)
		begin
			p = {rnd(), rnd()};
			ph = 3'h1 << (rnd() % 3);
			r = rnd();
			@(posedge clk);
			pos <= p;
			up <= k < 4 ? p : {rnd(), rnd()};
			lo <= k < 4 ? p : {rnd(), rnd()};
			pb <= 2'b11;
			me <= 2'b00;
			ac <= {2{ph[0]}};
			cr <= {2{ph[1]}};
			de <= {2{ph[2]}};
			jr <= r[1:0];
			host.wr(3'h0, k[0] ? 16'h021F : 16'h011F);
			host.rd(3'h1, w);
			cmp_word(w, exp_axis(k % 2));
		end
		@(posedge clk);
		{ac, cr, de, jr} <= '0;
		pb <= 2'b01;
		ie <= 2'b01;
		repeat (3) @(posedge clk);
		pb <= 2'b00;
		repeat (4) @(posedge clk);
		host.rd(3'h0, w);
		cmp_word(w & 16'h0003, 16'h0001);
		ip <= 2'b01;
		repeat (3) @(posedge clk);
		cmp_bits(busy, 2'b00);
		ie <= 2'b00;
		pos <= '0;
		up <= {2{32'h00000001}};
		lo <= '0;
		ae <= 2'b11;
		ehe <= 6'h3F;
		host.wr(3'h0, 16'h011F);
		// Causes in order: limits, alarm, emergency, three halts, software limit
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			pb <= 2'b01;
			repeat (2) @(posedge clk);
			lp <= {1'b0, i == 0};
			lm <= {1'b0, i == 1};
			al <= {1'b0, i == 2};
			emg_n <= i != 3;
			eh <= (i > 3 && i < 7) ? 6'h01 << (i - 4) : 6'h00;
			slp <= {1'b0, i == 7};
			repeat (3) @(posedge clk);
			cmp_bits(halt, 2'b01);
			{pb, lp, lm, al, eh, slp} <= '0;
			emg_n <= 1'b1;
			repeat (3) @(posedge clk);
			host.rd(3'h1, w);
			cmp_word(w, i < 4 ? 16'h1000 << i : i < 7 ? 16'h0100 << (i - 4) : 16'h0000);
			host.rd(3'h0, w);
			// Emergency is shared, so Y latches it too; external halts leave the error bit alone
			cmp_word(w & 16'h0030, i == 3 ? 16'h0030 : (i > 3 && i < 7) ? 16'h0000 : 16'h0010);
			host.wr(3'h0, i == 3 ? 16'h0325 : i > 3 ? {8'h01, 8'h20 + 8'(i - 4)} : 16'h0125);
			host.rd(3'h0, w);
			cmp_word(w & 16'h0030, 16'h0000);
			host.rd(3'h1, w);
			cmp_word(w, 16'h0000);
		end
		// Stop commands end a busy drive without latching a finish cause
		@(posedge clk);
		pb <= 2'b11;
		repeat (2) @(posedge clk);
		for (int j = 0; j < 2; j++)
		begin
			host.wr(3'h0, j ? 16'h0227 : 16'h0126);
			@(posedge clk);
			cmp_bits(halt, j ? 2'b10 : 2'b01);
		end
		host.rd(3'h1, w);
		cmp_word(w, 16'h0000);
		summarize();
	end
endmodule : test_motion_status_registers
